//--- logic/cerc_line_mem.sv
// small memory of backup cache lines with registered read data
// assumes synchronous write, one read port, one clock
`timescale 1ns/10ps
`default_nettype none
module cerc_line_mem (
  input  wire logic                       i_mclk,
  input  wire logic                       i_we,
  input  wire logic [cerc_pkg::IDX_W-1:0] i_widx,
  input  wire logic [cerc_pkg::DATA_W:0]  i_wdata,
  input  wire logic [cerc_pkg::IDX_W-1:0] i_ridx,
  output logic      [cerc_pkg::DATA_W:0]  o_rdata
);
  logic [cerc_pkg::DATA_W:0] mem [cerc_pkg::NLINES];
  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_widx] <= i_wdata;
    end
    o_rdata <= mem[i_ridx];
  end
endmodule
`default_nettype wire

//--- logic/cerc_pkg.sv
// package for the cache error recovery control block
// assumes a single core clock domain
package cerc_pkg;
  localparam int IDX_W    = 4;
  localparam int DATA_W   = 32;
  localparam int SYND_W   = 8;
  localparam int ADDR_W   = 32;
  localparam int TLB_N    = 8;
  localparam int TLB_AW   = 3;
  localparam int NLINES   = 16;
  localparam int IC_NLINE = 8;
  localparam int IC_AW    = 3;
  localparam int PROC_BIT = 31;
  localparam int IPL_W    = 5;
  // bus interface status field positions
  localparam int BS_FILL_ECC = 0;
  localparam int BS_HARD     = 1;
  localparam int BS_SOFT     = 2;
  localparam int BS_SEO      = 3;
  localparam int BS_W        = 4;
  // backup cache control field positions
  localparam int BC_EN_BIT   = 0;
  localparam int BC_FH_BIT   = 1;
  localparam int BC_W        = 2;
  // error interrupt levels and control reset value
  localparam logic [4:0] HARD_IPL = 5'h1D;
  localparam logic [4:0] SOFT_IPL = 5'h1A;
  localparam logic [1:0] CTL_RST  = 2'h0;
  // step of the retry sequencer
  typedef enum logic [1:0] {
    CERC_RUN   = 2'b00,
    CERC_ABORT = 2'b01,
    CERC_TAKE  = 2'b10
  } cerc_step_type;
endpackage

//--- logic/cerc_top.sv
// cache, translation buffer and error retry control
// assumes privileged register writes arrive as one-cycle pulses on i_mclk
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - instruction cache fully invalidated by each return from exception
// - tlb cleared only by invalidate-single, invalidate-all, context load, tlb parity error
// - tlb parity error triggers internal invalidate-all
// - cache errors automatically turn the affected cache off
// - backup control write can select force-hit mode
// - force-hit read returns line data unless uncorrectable
// - fill ecc checked in force-hit, sets fill-ecc flag
// - error-disable mode reloads syndrome on every fill
// - otherwise syndrome captured only on error
// - primary and icache arrays accept forced bad parity
// - tlb entries writable through tag and entry registers
// - machine check aborts; return re-executes failing instruction unless an error interrupt is taken
// - error interrupts taken only at instruction boundaries
// - after return, interrupt taken only if level below it
// - writing 0 to backup bit 0 disables backup, and primary unless primary control written same cycle
// - error flags cleared only by writing one
// - second hard or fill-ecc error sets flag, first address and status kept
module cerc_top (
  input  wire logic                        i_mclk,
  input  wire logic                        i_nrst,
  input  wire logic                        i_ic_ctl_we,
  input  wire logic                        i_ic_ctl_en,
  input  wire logic                        i_pc_ctl_we,
  input  wire logic                        i_pc_ctl_en,
  input  wire logic                        i_bc_ctl_we,
  input  wire logic [cerc_pkg::BC_W-1:0]   i_bc_ctl,
  input  wire logic                        i_diag_err_dis,
  input  wire logic                        i_rei,
  input  wire logic                        i_load_process_context,
  input  wire logic                        i_tlb_inv_all,
  input  wire logic                        i_tlb_inv_single,
  input  wire logic [cerc_pkg::ADDR_W-1:0] i_tlb_va,
  input  wire logic                        i_tlb_we,
  input  wire logic [cerc_pkg::TLB_AW-1:0] i_tlb_widx,
  input  wire logic [cerc_pkg::ADDR_W-1:0] i_tlb_tag,
  input  wire logic [cerc_pkg::ADDR_W-1:0] i_tlb_pte,
  input  wire logic                        i_tlb_par_err,
  input  wire logic                        i_ic_we,
  input  wire logic [cerc_pkg::IC_AW-1:0]  i_ic_addr,
  input  wire logic                        i_ic_bad_par,
  input  wire logic                        i_ic_par_err,
  input  wire logic                        i_pc_we,
  input  wire logic                        i_pc_bad_par,
  input  wire logic                        i_pc_par_err,
  input  wire logic                        i_fill,
  input  wire logic [cerc_pkg::IDX_W-1:0]  i_fill_idx,
  input  wire logic [cerc_pkg::DATA_W-1:0] i_fill_data,
  input  wire logic [cerc_pkg::SYND_W-1:0] i_fill_synd,
  input  wire logic                        i_fill_unc,
  input  wire logic [cerc_pkg::ADDR_W-1:0] i_fill_addr,
  input  wire logic                        i_rd,
  input  wire logic [cerc_pkg::IDX_W-1:0]  i_rd_idx,
  input  wire logic                        i_hard_err,
  input  wire logic [cerc_pkg::ADDR_W-1:0] i_err_addr,
  input  wire logic                        i_bs_w1c_we,
  input  wire logic [cerc_pkg::BS_W-1:0]   i_bs_w1c,
  input  wire logic                        i_mchk,
  input  wire logic                        i_insn_end,
  input  wire logic [cerc_pkg::IPL_W-1:0]  i_ipl,
  output logic                             o_ic_en,
  output logic                             o_pc_en,
  output logic                             o_bc_en,
  output logic                             o_force_hit,
  output logic [cerc_pkg::IC_NLINE-1:0]    o_ic_valid,
  output logic [cerc_pkg::IC_NLINE-1:0]    o_ic_par,
  output logic                             o_pc_par,
  output logic [cerc_pkg::TLB_N-1:0]       o_tlb_valid,
  output logic [cerc_pkg::ADDR_W-1:0]      o_tlb_rd_pte,
  output logic                             o_rd_valid,
  output logic [cerc_pkg::DATA_W-1:0]      o_rd_data,
  output logic [cerc_pkg::BS_W-1:0]        o_bus_status,
  output logic [cerc_pkg::ADDR_W-1:0]      o_err_addr,
  output logic [cerc_pkg::SYND_W-1:0]      o_fill_synd,
  output logic                             o_abort,
  output logic                             o_retry,
  output logic                             o_err_int
);
  localparam int N = cerc_pkg::TLB_N;

  typedef struct packed {
    logic                        ic_en;
    logic                        pc_en;
    logic                        bc_en;
    logic                        fh;
    logic [cerc_pkg::IC_NLINE-1:0] ic_v;
    logic [cerc_pkg::IC_NLINE-1:0] ic_p;
    logic                        pc_p;
    logic [N-1:0]                tv;
    logic [N-1:0][cerc_pkg::ADDR_W-1:0] ttag;
    logic [N-1:0][cerc_pkg::ADDR_W-1:0] tpte;
    logic [cerc_pkg::ADDR_W-1:0] rd_pte;
    logic                        rd_pend;
    logic                        rd_v;
    logic [cerc_pkg::DATA_W-1:0] rd_d;
    logic [cerc_pkg::BS_W-1:0]   bs;
    logic [cerc_pkg::ADDR_W-1:0] ea;
    logic [cerc_pkg::SYND_W-1:0] syn;
    cerc_pkg::cerc_step_type     step;
    logic                        abort;
    logic                        retry;
    logic                        eint;
  } cerc_state_type;

  cerc_state_type s_q;
  cerc_state_type s_d;
  logic [cerc_pkg::DATA_W:0] mem_rd;
  logic                      err_new;
  logic                      pend_int;
  logic [cerc_pkg::IPL_W-1:0] int_ipl;

  cerc_line_mem cerc_line_mem_inst (
    .i_mclk  (i_mclk),
    .i_we    (i_fill),
    .i_widx  (i_fill_idx),
    .i_wdata ({i_fill_unc, i_fill_data}),
    .i_ridx  (i_rd_idx),
    .o_rdata (mem_rd)
  );

  always_comb begin
    s_d = s_q;
    s_d.abort = 1'b0;
    s_d.retry = 1'b0;
    if (i_bc_ctl_we) begin
      s_d.bc_en = i_bc_ctl[cerc_pkg::BC_EN_BIT];
      s_d.fh = i_bc_ctl[cerc_pkg::BC_FH_BIT];
      if (!i_bc_ctl[cerc_pkg::BC_EN_BIT]) begin
        s_d.pc_en = 1'b0;
      end
    end
    if (i_pc_ctl_we) begin
      s_d.pc_en = i_pc_ctl_en;
    end
    if (i_ic_ctl_we) begin
      s_d.ic_en = i_ic_ctl_en;
    end
    if (i_ic_we) begin
      s_d.ic_v[i_ic_addr] = 1'b1;
      s_d.ic_p[i_ic_addr] = i_ic_bad_par;
    end
    if (i_pc_we) begin
      s_d.pc_p = i_pc_bad_par;
    end
    if (i_rei) begin
      s_d.ic_v = '0;
    end
    if (i_tlb_we) begin
      s_d.tv[i_tlb_widx] = 1'b1;
      s_d.ttag[i_tlb_widx] = i_tlb_tag;
      s_d.tpte[i_tlb_widx] = i_tlb_pte;
    end
    for (int k = 0; k < N; k++) begin
      if (i_tlb_inv_single && s_q.ttag[k] == i_tlb_va) begin
        s_d.tv[k] = 1'b0;
      end
      if (i_load_process_context && !s_q.ttag[k][cerc_pkg::PROC_BIT]) begin
        s_d.tv[k] = 1'b0;
      end
      if (s_q.tv[k] && s_q.ttag[k] == i_tlb_va) begin
        s_d.rd_pte = s_q.tpte[k];
      end
    end
    if (i_tlb_inv_all || i_tlb_par_err) begin
      s_d.tv = '0;
    end
    if (i_ic_par_err) begin
      s_d.ic_en = 1'b0;
    end
    if (i_pc_par_err) begin
      s_d.pc_en = 1'b0;
    end
    if (i_fill && i_fill_unc) begin
      s_d.bc_en = 1'b0;
      s_d.pc_en = 1'b0;
    end
    s_d.rd_pend = i_rd && s_q.fh;
    s_d.rd_v = s_q.rd_pend && !mem_rd[cerc_pkg::DATA_W];
    if (s_q.rd_pend && !mem_rd[cerc_pkg::DATA_W]) begin
      s_d.rd_d = mem_rd[cerc_pkg::DATA_W-1:0];
    end
    if (i_bs_w1c_we) begin
      s_d.bs = s_q.bs & ~i_bs_w1c;
    end
    if (err_new) begin
      if (s_q.bs[cerc_pkg::BS_FILL_ECC] || s_q.bs[cerc_pkg::BS_HARD]) begin
        s_d.bs[cerc_pkg::BS_SEO] = 1'b1;
      end else begin
        s_d.ea = i_hard_err ? i_err_addr : i_fill_addr;
        s_d.bs[cerc_pkg::BS_FILL_ECC] = i_fill && i_fill_unc;
        s_d.bs[cerc_pkg::BS_HARD] = i_hard_err;
      end
    end
    if (i_pc_par_err || i_ic_par_err) begin
      s_d.bs[cerc_pkg::BS_SOFT] = 1'b1;
    end
    if (i_fill && (i_diag_err_dis || i_fill_unc)) begin
      s_d.syn = i_fill_synd;
    end
    s_d.eint = pend_int && (s_q.eint || i_insn_end);
    unique case (s_q.step)
      cerc_pkg::CERC_RUN: begin
        if (i_mchk) begin
          s_d.abort = 1'b1;
          s_d.step = cerc_pkg::CERC_ABORT;
        end
      end
      cerc_pkg::CERC_ABORT: begin
        if (i_rei) begin
          if (pend_int && i_ipl < int_ipl) begin
            s_d.step = cerc_pkg::CERC_TAKE;
          end else begin
            s_d.retry = 1'b1;
            s_d.step = cerc_pkg::CERC_RUN;
          end
        end
      end
      cerc_pkg::CERC_TAKE: begin
        if (i_insn_end) begin
          s_d.step = cerc_pkg::CERC_RUN;
        end
      end
      default: s_d.step = cerc_pkg::CERC_RUN;
    endcase
  end

  assign err_new = i_hard_err || (i_fill && i_fill_unc);
  assign pend_int = s_q.bs[cerc_pkg::BS_HARD] ||
                    s_q.bs[cerc_pkg::BS_SOFT] ||
                    s_q.bs[cerc_pkg::BS_FILL_ECC];
  assign int_ipl = s_q.bs[cerc_pkg::BS_HARD] ? cerc_pkg::HARD_IPL
                                             : cerc_pkg::SOFT_IPL;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_ic_en      = s_q.ic_en;
  assign o_pc_en      = s_q.pc_en;
  assign o_bc_en      = s_q.bc_en;
  assign o_force_hit  = s_q.fh;
  assign o_ic_valid   = s_q.ic_v;
  assign o_ic_par     = s_q.ic_p;
  assign o_pc_par     = s_q.pc_p;
  assign o_tlb_valid  = s_q.tv;
  assign o_tlb_rd_pte = s_q.rd_pte;
  assign o_rd_valid   = s_q.rd_v;
  assign o_rd_data    = s_q.rd_d;
  assign o_bus_status = s_q.bs;
  assign o_err_addr   = s_q.ea;
  assign o_fill_synd  = s_q.syn;
  assign o_abort      = s_q.abort;
  assign o_retry      = s_q.retry;
  assign o_err_int    = s_q.eint;
endmodule
`default_nettype wire

//--- tb/cerc_props.sv
// assertions on the ports of cerc_top
// assumes one clock i_mclk and async active-low i_nrst
`timescale 1ns/10ps
`default_nettype none
module cerc_props (
  input wire logic       i_mclk,
  input wire logic       i_nrst,
  input wire logic       i_rei,
  input wire logic       i_ic_we,
  input wire logic       i_tlb_we,
  input wire logic       i_tlb_par_err,
  input wire logic       i_ic_par_err,
  input wire logic       i_ic_ctl_we,
  input wire logic       i_pc_ctl_we,
  input wire logic       i_bc_ctl_we,
  input wire logic [1:0] i_bc_ctl,
  input wire logic       i_mchk,
  input wire logic       i_rd,
  input wire logic       i_bs_w1c_we,
  input wire logic [3:0] i_bs_w1c,
  input wire logic [7:0] o_ic_valid,
  input wire logic [7:0] o_tlb_valid,
  input wire logic       o_ic_en,
  input wire logic       o_pc_en,
  input wire logic       o_bc_en,
  input wire logic       o_force_hit,
  input wire logic [3:0] o_bus_status,
  input wire logic       o_abort,
  input wire logic       o_rd_valid,
  input wire logic       i_insn_end,
  input wire logic       o_err_int
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  property p_rei; i_rei && !i_ic_we |=> o_ic_valid == 8'h00; endproperty
  a_rei: assert property (p_rei) else $error("icache kept");
  property p_tpar; i_tlb_par_err && !i_tlb_we |=> !o_tlb_valid; endproperty
  a_tpar: assert property (p_tpar) else $error("tlb kept");
  property p_icoff;
    i_ic_par_err && !i_ic_ctl_we |=> !o_ic_en && o_bus_status[2];
  endproperty
  a_icoff: assert property (p_icoff) else $error("icache on");
  property p_bcoff;
    i_bc_ctl_we && !i_bc_ctl[0] && !i_pc_ctl_we |=> !o_pc_en && !o_bc_en;
  endproperty
  a_bcoff: assert property (p_bcoff) else $error("cache on");
  property p_fh; i_bc_ctl_we |=> o_force_hit == $past(i_bc_ctl[1]); endproperty
  a_fh: assert property (p_fh) else $error("force hit");
  property p_abt; i_mchk |=> o_abort; endproperty
  a_abt: assert property (p_abt) else $error("no abort");
  property p_rd; o_rd_valid |-> $past(i_rd, 2); endproperty
  a_rd: assert property (p_rd) else $error("read timing");
  property p_w1c;
    $fell(o_bus_status[2]) |-> $past(i_bs_w1c_we && i_bs_w1c[2]);
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag lost");
  property p_eint; $rose(o_err_int) |-> $past(i_insn_end); endproperty
  a_eint: assert property (p_eint) else $error("mid insn int");
  c_rd: cover property (o_rd_valid);
  c_abt: cover property (o_abort);
  c_seo: cover property (o_bus_status[3]);
endmodule
bind cerc_top cerc_props cerc_props_inst (.*);
`default_nettype wire

//--- tb/cerc_top_test.sv
// directed testbench of cerc_top
// assumes cerc_pkg, cerc_top and cerc_props compiled first
`timescale 1ns/10ps
`default_nettype none
module cerc_top_test;
  logic i_mclk=0,i_nrst=0,i_ic_ctl_we=0,i_ic_ctl_en=0,i_pc_ctl_we=0;
  logic i_pc_ctl_en=0,i_bc_ctl_we=0,i_diag_err_dis=0,i_rei=0,i_load_process_context=0;
  logic i_tlb_inv_all=0,i_tlb_inv_single=0,i_tlb_we=0,i_tlb_par_err=0;
  logic i_ic_we=0,i_ic_bad_par=0,i_ic_par_err=0,i_pc_we=0,i_pc_bad_par=0;
  logic i_pc_par_err=0,i_fill=0,i_fill_unc=0,i_rd=0,i_hard_err=0;
  logic i_bs_w1c_we=0,i_mchk=0,i_insn_end=0;
  logic [1:0] i_bc_ctl=0;
  logic [2:0] i_tlb_widx=0,i_ic_addr=0;
  logic [3:0] i_fill_idx=0,i_rd_idx=0,i_bs_w1c=0,o_bus_status;
  logic [4:0] i_ipl=0;
  logic [7:0] i_fill_synd=0,o_ic_valid,o_ic_par,o_tlb_valid,o_fill_synd;
  logic [31:0] i_tlb_va=0,i_tlb_tag=0,i_tlb_pte=0,i_fill_data=0;
  logic [31:0] i_fill_addr=0,i_err_addr=0,o_tlb_rd_pte,o_rd_data,o_err_addr;
  logic o_ic_en,o_pc_en,o_bc_en,o_force_hit,o_pc_par,o_rd_valid;
  logic o_abort,o_retry,o_err_int;
  int fail_count = 0;
  int samples_checked = 0;
  // ic_we ic_en pc_we pc_en bc_we bc[1:0] | ic pc bc fh
  logic [10:0] rows [11] = '{11'h052, 11'h186, 11'h60E, 11'h406, 11'h102,
    11'h040, 11'h052, 11'h186, 11'h077, 11'h061, 11'h052};
  cerc_top cerc_top_inst (.*);
  always #25 i_mclk = ~i_mclk;
  task automatic tk();
    @(posedge i_mclk);
    #1;
  endtask
  task automatic pl(ref logic s);
    tk();
    s = 1;
    tk();
    s = 0;
  endtask
  task automatic tw(logic [2:0] x, logic [31:0] t, logic [31:0] p);
    i_tlb_widx = x;
    i_tlb_tag = t;
    i_tlb_pte = p;
    pl(i_tlb_we);
  endtask
  task automatic chk(logic [35:0] seen, logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    fail_count++;
    conclude();
  end
  initial begin
    repeat (16) tk();
    chk({o_ic_en, o_pc_en, o_bc_en, o_bus_status, o_ic_valid}, 0); // rst
    chk(o_tlb_valid, 0); // rst
    i_nrst = 1;
    pl(i_tlb_inv_all);
    for (int a = 0; a < 8; a++) begin
      i_ic_addr = a[2:0];
      pl(i_ic_we);
    end
    pl(i_rei);
    chk(o_ic_valid, 0); // after flush
    foreach (rows[k]) begin
      tk();
      {i_ic_ctl_we, i_ic_ctl_en, i_pc_ctl_we, i_pc_ctl_en, i_bc_ctl_we,
        i_bc_ctl} = rows[k][10:4];
      tk();
      {i_ic_ctl_we, i_pc_ctl_we, i_bc_ctl_we} = 3'h0;
      chk({o_ic_en, o_pc_en, o_bc_en, o_force_hit}, rows[k][3:0]); // seq
    end
    i_ic_addr = 3'h5;
    i_ic_bad_par = 1;
    i_pc_bad_par = 1;
    i_pc_we = 1;
    pl(i_ic_we);
    i_pc_we = 0;
    chk({o_ic_valid, o_ic_par, o_pc_par}, 17'h04041); // par
    pl(i_rei);
    chk(o_ic_valid, 0); // flush
    i_tlb_va = 32'h00001000;
    tw(3'h1, 32'h00001000, 32'h000000A5);
    tw(3'h6, 32'h80002000, 32'h0000005A);
    tk();
    chk(o_tlb_rd_pte, 32'h000000A5); // read
    chk(o_tlb_valid, 8'h42); // write
    pl(i_load_process_context);
    chk(o_tlb_valid, 8'h40); // ctx
    i_tlb_va = 32'h80002000;
    pl(i_tlb_inv_single);
    chk(o_tlb_valid, 0); // single
    tw(3'h2, 32'h80003000, 32'h00000011);
    pl(i_tlb_inv_all);
    chk(o_tlb_valid, 0); // all
    tw(3'h3, 32'h80004000, 32'h00000022);
    pl(i_tlb_par_err);
    chk(o_tlb_valid, 0); // parity
    i_ic_ctl_en = 1;
    pl(i_ic_ctl_we);
    pl(i_ic_par_err);
    chk({o_ic_en, o_bus_status[2]}, 2'h1); // icache
    i_bs_w1c = 4'h1;
    pl(i_bs_w1c_we);
    chk(o_bus_status, 4'h4); // other bit
    i_bs_w1c = 4'h4;
    pl(i_bs_w1c_we);
    chk(o_bus_status, 0); // clear
    i_pc_ctl_en = 1;
    pl(i_pc_ctl_we);
    pl(i_pc_par_err);
    chk(o_pc_en, 0); // primary
    i_err_addr = 32'h00000100;
    pl(i_hard_err);
    i_err_addr = 32'h00000200;
    pl(i_hard_err);
    chk({o_bus_status, o_err_addr}, 36'hE00000100); // second
    pl(i_mchk);
    chk(o_abort, 1); // abort
    pl(i_rei);
    chk(o_retry, 0); // low level
    chk(o_err_int, 0); // no boundary
    pl(i_insn_end);
    chk(o_err_int, 1); // boundary
    pl(i_mchk);
    chk(o_abort, 1); // second abort
    i_ipl = 5'h1F;
    pl(i_rei);
    chk(o_retry, 1); // high level
    i_bs_w1c = 4'hF;
    pl(i_bs_w1c_we);
    i_diag_err_dis = 1;
    i_fill_idx = 4'h3;
    i_fill_data = 32'hCAFE0003;
    i_fill_synd = 8'h5C;
    pl(i_fill);
    chk(o_fill_synd, 8'h5C); // reload
    i_bc_ctl = 2'h3;
    pl(i_bc_ctl_we);
    i_rd_idx = 4'h3;
    pl(i_rd);
    chk(o_rd_valid, 0); // early
    tk();
    chk({o_rd_valid, o_rd_data}, 33'h1CAFE0003); // data
    i_fill_unc = 1;
    i_fill_idx = 4'h4;
    pl(i_fill);
    chk({o_bus_status[0], o_pc_en, o_bc_en}, 3'h4); // ecc
    pl(i_bc_ctl_we);
    i_rd_idx = 4'h4;
    pl(i_rd);
    tk();
    chk(o_rd_valid, 0); // refused
    i_diag_err_dis = 0;
    i_fill_unc = 0;
    i_fill_synd = 8'h33;
    pl(i_fill);
    chk(o_fill_synd, 8'h5C); // no error
    i_fill_unc = 1;
    pl(i_fill);
    chk(o_fill_synd, 8'h33); // error
    conclude();
  end
endmodule
`default_nettype wire
